// ===== hdl/fsle_defs.svh
/*
 * Timing counts and field constants for the fieldbus status indicator encoder.
 * Assumes a 40 MHz system clock.
 */
`ifndef FSLE_DEFS_SVH
`define FSLE_DEFS_SVH

`define FSLE_CLK_HZ          40000000
`define FSLE_FLASH_HALF_MS   500
`define FSLE_FLICKER_HALF_MS 50
`define FSLE_ERR_BLINK_MS    400
`define FSLE_ERR_TOGGLE_MS   100
`define FSLE_MS_CYCLES       (`FSLE_CLK_HZ / 1000)
`define FSLE_ADDR_LIMIT      65
`define FSLE_BAUD_LIMIT      5
`define FSLE_IRQ_SWCHG       0
`define FSLE_IRQ_CRC         1
`define FSLE_IRQ_STOP        2
`define FSLE_IRQ_SEVERE      3
`define FSLE_REG_STATUS      4'h0
`define FSLE_REG_MASK        4'h1
`define FSLE_REG_CTRL        4'h2
`define FSLE_REG_LED         4'h3
`define FSLE_CTRL_MODE_BIT   0

`endif

// ===== hdl/fsle_encoder.sv
/*
 * Status indicator encoder: master mode drives one duo indicator, slave mode
 * drives a run and an error indicator, with a small register port and interrupt.
 * Assumes status flags come from the stack on clk; switches are pins.
 */
// Contract
// RULE_01 - Master: steady green when running without fault.
// RULE_02 - Master: flash green on configuration fault; code flashes only while dataExchange is also set, else dark.
// RULE_03 - Master: flicker green when communication halted.
// RULE_04 - Master: steady red on severe fault.
// RULE_05 - Master: dark when no configuration present.
// RULE_06 - Flash toggles slowly; steady holds constant.
// RULE_07 - Flicker toggles clearly faster than flash.
// RULE_08 - Slave: run on when joined with refresh.
// RULE_09 - Slave: run off before join, carrier, timeout, reset.
// RULE_10 - Slave: error blinks 0.4 s on switch change.
// RULE_11 - Slave: error steady on CRC or bad address.
// RULE_12 - Slave: error steady when captured baud five+.
// RULE_13 - Error off normally; steady beats blink.
// RULE_14 - Master priority: severe, none, stopped, fault, normal.
`timescale 1ns/100ps
`default_nettype none
`include "fsle_defs.svh"

module fsle_encoder #(
    parameter int FLASH_HALF_CYCLES   = `FSLE_FLASH_HALF_MS * `FSLE_MS_CYCLES,
    parameter int FLICKER_HALF_CYCLES = `FSLE_FLICKER_HALF_MS * `FSLE_MS_CYCLES,
    parameter int ERR_TOGGLE_CYCLES   = `FSLE_ERR_TOGGLE_MS * `FSLE_MS_CYCLES,
    parameter int ERR_BLINK_TICKS     = `FSLE_ERR_BLINK_MS / `FSLE_ERR_TOGGLE_MS
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire fsle_pkg::fsle_master_t masterIn,
    input  wire fsle_pkg::fsle_slave_t  slaveIn,
    input  wire logic [3:0]            regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic [31:0]                regRdata,
    output logic                       irq,
    output fsle_pkg::fsle_led_t        duoLed,
    output logic                       runLed,
    output logic                       errLed
);
    logic flashTick;
    logic flickerTick;
    logic errTick;

    fsle_timebase #(.HALF_CYCLES(FLASH_HALF_CYCLES)) uFlash (
        .clk   (clk),
        .reset (reset),
        .tick  (flashTick)
    );
    fsle_timebase #(.HALF_CYCLES(FLICKER_HALF_CYCLES)) uFlicker (
        .clk   (clk),
        .reset (reset),
        .tick  (flickerTick)
    );
    fsle_timebase #(.HALF_CYCLES(ERR_TOGGLE_CYCLES)) uErr (
        .clk   (clk),
        .reset (reset),
        .tick  (errTick)
    );

    // Switches are pins, so two flops before any use.
    logic [7:0] swMeta_reg;
    logic [7:0] swSync_reg;
    logic [7:0] swCapt_reg;
    logic       captured_reg;
    logic [7:0] swPrev_reg;
    logic [7:0] swCapt_next;
    logic       captured_next;
    logic [1:0] fill_reg;
    logic [1:0] fill_next;

    logic       flashPh_reg;
    logic       flashPh_next;
    logic       flickPh_reg;
    logic       flickPh_next;
    logic [3:0] blinkCnt_reg;
    logic [3:0] blinkCnt_next;
    logic       blinkPh_reg;
    logic       blinkPh_next;
    logic [3:0] irqStat_reg;
    logic [3:0] irqStat_next;
    logic [3:0] irqMask_reg;
    logic [3:0] irqMask_next;
    logic       mode_reg;
    logic       mode_next;
    logic [31:0] rdata_next;
    fsle_pkg::fsle_led_t duo_next;
    logic       run_next;
    logic       err_next;
    logic       swChanged;
    logic       errSteady;
    logic [3:0] events;
    logic [7:0] addrSum;

    always_comb begin
        // The synchroniser still holds reset zeros for two cycles, so capture waits.
        fill_next = (fill_reg == 2'h3) ? fill_reg : fill_reg + 2'h1;
        swCapt_next = swCapt_reg;
        captured_next = captured_reg;
        if (!captured_reg && fill_reg == 2'h3 && swPrev_reg == swSync_reg) begin // RULE_12
            swCapt_next = swSync_reg;
            captured_next = 1'b1;
        end
        flashPh_next = flashTick ? ~flashPh_reg : flashPh_reg; // RULE_06
        flickPh_next = flickerTick ? ~flickPh_reg : flickPh_reg; // RULE_07
        swChanged = captured_reg && (swSync_reg != swPrev_reg)
                    && (swSync_reg != swCapt_reg);
        blinkCnt_next = blinkCnt_reg;
        blinkPh_next = blinkPh_reg;
        if (swChanged) begin // RULE_10
            blinkCnt_next = 4'(ERR_BLINK_TICKS);
            blinkPh_next = 1'b1;
        end else if (errTick && blinkCnt_reg != 4'h0) begin
            blinkCnt_next = blinkCnt_reg - 4'h1;
            blinkPh_next = ~blinkPh_reg;
        end
        addrSum = {1'b0, slaveIn.stationAddr} + {5'h0, slaveIn.occupied};
        errSteady = slaveIn.crcError || slaveIn.stationAddr == 7'h0 // RULE_11
                    || addrSum >= 8'(`FSLE_ADDR_LIMIT)
                    || (captured_reg && swCapt_reg[7:4] >= 4'(`FSLE_BAUD_LIMIT)); // RULE_12
        duo_next = '0;
        if (!masterIn.cfgPresent) begin // RULE_14
            duo_next = '0; // RULE_05
        end else if (masterIn.commStopped) begin
            duo_next.green = flickPh_reg; // RULE_03
        end else if (masterIn.cfgFault && masterIn.dataExchange) begin
            duo_next.green = flashPh_reg; // RULE_02
        end else if (masterIn.dataExchange) begin
            duo_next.green = 1'b1; // RULE_01
        end
        if (masterIn.severeFault) begin // RULE_14
            duo_next.green = 1'b0;
            duo_next.red = 1'b1; // RULE_04
        end
        run_next = slaveIn.joined && slaveIn.refreshOk && !slaveIn.carrierLost // RULE_08
                   && !slaveIn.timedOut && !slaveIn.hwReset; // RULE_09
        if (slaveIn.hwReset) begin
            err_next = 1'b0; // RULE_13
        end else if (errSteady) begin
            err_next = 1'b1; // RULE_13
        end else begin
            err_next = (blinkCnt_reg != 4'h0) && blinkPh_reg;
        end
        if (mode_reg == fsle_pkg::FSLE_MODE_MASTER) begin
            run_next = 1'b0;
            err_next = 1'b0;
        end else begin
            duo_next = '0;
        end
        events = '0;
        events[`FSLE_IRQ_SWCHG] = swChanged;
        events[`FSLE_IRQ_CRC] = slaveIn.crcError;
        events[`FSLE_IRQ_STOP] = masterIn.commStopped;
        events[`FSLE_IRQ_SEVERE] = masterIn.severeFault;
        irqStat_next = irqStat_reg;
        irqMask_next = irqMask_reg;
        mode_next = mode_reg;
        if (regWr) begin
            case (regAddr)
                `FSLE_REG_STATUS: irqStat_next = irqStat_reg & ~regWdata[3:0];
                `FSLE_REG_MASK:   irqMask_next = regWdata[3:0];
                `FSLE_REG_CTRL:   mode_next = regWdata[`FSLE_CTRL_MODE_BIT];
                default:          ;
            endcase
        end
        // Set beats clear so no event is lost in the clearing cycle.
        irqStat_next = irqStat_next | events;
        rdata_next = 32'h0;
        if (regRd) begin
            case (regAddr)
                `FSLE_REG_STATUS: rdata_next = {28'h0, irqStat_reg};
                `FSLE_REG_MASK:   rdata_next = {28'h0, irqMask_reg};
                `FSLE_REG_CTRL:   rdata_next = {31'h0, mode_reg};
                `FSLE_REG_LED:    rdata_next = {28'h0, duoLed.green, duoLed.red,
                                                runLed, errLed};
                default:          rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            swMeta_reg   <= 8'h0;
            swSync_reg   <= 8'h0;
            swCapt_reg   <= 8'h0;
            swPrev_reg   <= 8'h0;
            captured_reg <= 1'b0;
            fill_reg     <= 2'h0;
            flashPh_reg  <= 1'b0;
            flickPh_reg  <= 1'b0;
            blinkCnt_reg <= 4'h0;
            blinkPh_reg  <= 1'b0;
            irqStat_reg  <= 4'h0;
            irqMask_reg  <= 4'h0;
            mode_reg     <= 1'b0;
            regRdata     <= 32'h0;
            duoLed       <= '0;
            runLed       <= 1'b0;
            errLed       <= 1'b0;
        end else begin
            swMeta_reg   <= {slaveIn.baudSwitch, slaveIn.stationSwitch};
            swSync_reg   <= swMeta_reg;
            swPrev_reg   <= swSync_reg;
            fill_reg     <= fill_next;
            swCapt_reg   <= swCapt_next;
            captured_reg <= captured_next;
            flashPh_reg  <= flashPh_next;
            flickPh_reg  <= flickPh_next;
            blinkCnt_reg <= blinkCnt_next;
            blinkPh_reg  <= blinkPh_next;
            irqStat_reg  <= irqStat_next;
            irqMask_reg  <= irqMask_next;
            mode_reg     <= mode_next;
            regRdata     <= rdata_next;
            duoLed       <= duo_next;
            runLed       <= run_next;
            errLed       <= err_next;
        end
    end

    assign irq = |(irqStat_reg & irqMask_reg);

    AST_SEVERE_RED: assert property (@(posedge clk) disable iff (reset) // RULE_04
        mode_reg == 1'b0 && masterIn.severeFault |=> duoLed.red && !duoLed.green)
        else $error("Severe fault did not give steady red.");
    AST_NOCFG_DARK: assert property (@(posedge clk) disable iff (reset) // RULE_05
        mode_reg == 1'b0 && !masterIn.cfgPresent && !masterIn.severeFault
        |=> duoLed == '0)
        else $error("Missing configuration did not darken duo.");
    AST_RUN_GREEN: assert property (@(posedge clk) disable iff (reset) // RULE_01
        mode_reg == 1'b0 && masterIn.cfgPresent && masterIn.dataExchange
        && !masterIn.cfgFault && !masterIn.commStopped && !masterIn.severeFault
        |=> duoLed.green)
        else $error("Normal exchange did not give steady green.");
    AST_FLASH_SLOW: assert property (@(posedge clk) disable iff (reset) // RULE_02
        mode_reg == 1'b0 && masterIn.cfgPresent && masterIn.cfgFault
        && masterIn.dataExchange && !masterIn.commStopped && !masterIn.severeFault
        |=> duoLed.green == $past(flashPh_reg))
        else $error("Configuration fault not flashing.");
    AST_FLICKER: assert property (@(posedge clk) disable iff (reset) // RULE_03
        mode_reg == 1'b0 && masterIn.cfgPresent && masterIn.commStopped
        && !masterIn.severeFault |=> duoLed.green == $past(flickPh_reg))
        else $error("Stopped communication not flickering.");
    AST_FLASH_TOGGLE: assert property (@(posedge clk) disable iff (reset) // RULE_06
        flashTick |=> flashPh_reg != $past(flashPh_reg))
        else $error("Flash phase did not toggle on tick.");
    AST_FLICK_HOLD: assert property (@(posedge clk) disable iff (reset) // RULE_07
        !flickerTick |=> flickPh_reg == $past(flickPh_reg))
        else $error("Flicker phase moved without tick.");
    AST_RUN_OFF: assert property (@(posedge clk) disable iff (reset) // RULE_09
        slaveIn.hwReset || slaveIn.carrierLost || slaveIn.timedOut |=> !runLed)
        else $error("Run indicator lit during fault.");
    AST_RUN_ON: assert property (@(posedge clk) disable iff (reset) // RULE_08
        mode_reg == 1'b1 && slaveIn.joined && slaveIn.refreshOk && !slaveIn.hwReset
        && !slaveIn.carrierLost && !slaveIn.timedOut |=> runLed)
        else $error("Run indicator dark while joined.");
    AST_ERR_STEADY: assert property (@(posedge clk) disable iff (reset) // RULE_11
        mode_reg == 1'b1 && slaveIn.crcError && !slaveIn.hwReset |=> errLed)
        else $error("CRC error did not light error indicator.");
    AST_BLINK_LOAD: assert property (@(posedge clk) disable iff (reset) // RULE_10
        swChanged |=> blinkCnt_reg == 4'(ERR_BLINK_TICKS))
        else $error("Switch change did not start blink.");
    AST_ERR_RESET_OFF: assert property (@(posedge clk) disable iff (reset) // RULE_13
        slaveIn.hwReset |=> !errLed)
        else $error("Error indicator lit during hardware reset.");
    AST_BAUD_BAD: assert property (@(posedge clk) disable iff (reset) // RULE_12
        mode_reg == 1'b1 && captured_reg && swCapt_reg[7:4] >= 4'h5 && !slaveIn.hwReset
        |=> errLed)
        else $error("Bad baud capture did not light error indicator.");
    AST_PRIO: assert property (@(posedge clk) disable iff (reset) // RULE_14
        mode_reg == 1'b0 && masterIn.severeFault && !masterIn.cfgPresent |=> duoLed.red)
        else $error("Severe fault lost priority.");

    COV_SEVERE: cover property (@(posedge clk) disable iff (reset) duoLed.red);
    COV_BLINK: cover property (@(posedge clk) disable iff (reset) swChanged);
    COV_IRQ: cover property (@(posedge clk) disable iff (reset) irq);
    COV_RUN: cover property (@(posedge clk) disable iff (reset) runLed);
    COV_FLICKER: cover property (@(posedge clk) disable iff (reset) flickerTick && duoLed.green);
endmodule

`default_nettype wire

// ===== hdl/fsle_pkg.sv
/*
 * Types for the fieldbus status indicator encoder.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none

package fsle_pkg;
    typedef enum logic {
        FSLE_MODE_MASTER,
        FSLE_MODE_SLAVE
    } fsle_mode_t;

    typedef struct packed {
        logic cfgPresent;
        logic cfgFault;
        logic dataExchange;
        logic commStopped;
        logic severeFault;
    } fsle_master_t;

    typedef struct packed {
        logic       joined;
        logic       refreshOk;
        logic       carrierLost;
        logic       timedOut;
        logic       hwReset;
        logic       crcError;
        logic [6:0] stationAddr;
        logic [2:0] occupied;
        logic [3:0] baudSwitch;
        logic [3:0] stationSwitch;
    } fsle_slave_t;

    typedef struct packed {
        logic green;
        logic red;
    } fsle_led_t;
endpackage

`default_nettype wire

// ===== hdl/fsle_timebase.sv
/*
 * Divider producing a one-cycle enable every HALF_CYCLES clock cycles.
 * Assumes a single system clock and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fsle_defs.svh"

module fsle_timebase #(
    parameter int HALF_CYCLES = 20000
) (
    input  wire logic clk,
    input  wire logic reset,
    output logic      tick
);
    logic [31:0] count_reg;
    logic [31:0] count_next;

    always_comb begin
        tick = (count_reg == 32'(HALF_CYCLES - 1));
        count_next = tick ? 32'h0 : count_reg + 32'h1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= 32'h0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

`default_nettype wire

// ===== verification/fsle_encoder_tb.sv
/*
 * Self-checking bench for the status indicator encoder.
 * Assumes short blink counts: flash 20, flicker 4, error toggle 8 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fsle_defs.svh"

module fsle_encoder_tb;
    logic                  clk = 1'b0;
    logic                  reset = 1'b1;
    fsle_pkg::fsle_master_t masterIn = '0;
    fsle_pkg::fsle_slave_t  slaveIn = '0;
    logic [3:0]            regAddr = 4'h0;
    logic [31:0]           regWdata = 32'h0;
    logic                  regWr = 1'b0;
    logic                  regRd = 1'b0;
    logic                  clr = 1'b0;
    logic [31:0]           regRdata;
    logic [31:0]           rd;
    logic                  irq;
    logic                  runLed;
    logic                  errLed;
    fsle_pkg::fsle_led_t   duoLed;
    int                    greenT;
    int                    redT;
    int                    errT;
    int                    failures = 0;
    int                    comparisons = 0;

    always #12.5 clk = ~clk;

    fsle_encoder #(.FLASH_HALF_CYCLES(20), .FLICKER_HALF_CYCLES(4), .ERR_TOGGLE_CYCLES(8),
                   .ERR_BLINK_TICKS(4)) dut_u (.clk(clk), .reset(reset), .masterIn(masterIn),
        .slaveIn(slaveIn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq), .duoLed(duoLed), .runLed(runLed),
        .errLed(errLed));

    fsle_led_observer obs_u (.clk(clk), .reset(reset), .clr(clr), .duoLed(duoLed),
        .errLed(errLed), .greenToggles(greenT), .redToggles(redT), .errToggles(errT));

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask

    // Window of 80 cycles: four flash halves or twenty flicker halves.
    task automatic window();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        settle(80);
    endtask

    task automatic do_reset(input logic [3:0] baud);
        @(posedge clk);
        reset <= 1'b1;
        slaveIn.baudSwitch <= baud;
        settle(6);
        chk({28'h0, duoLed, runLed, errLed}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        reset <= 1'b0;
        settle(10);
    endtask

    task automatic check_master(input logic [4:0] m, input logic [1:0] expLed, input int kind);
        @(posedge clk);
        masterIn <= m;
        settle(4);
        window();
        if (kind == 0) begin
            chk({30'h0, duoLed}, {30'h0, expLed});
            chk(greenT + redT, 32'h0);
        end else begin
            chk(redT, 32'h0);
            if (kind == 1) chk({31'h0, greenT >= 3 && greenT <= 5}, 32'h1);
            else chk({31'h0, greenT >= 15 && greenT <= 25}, 32'h1);
        end
    endtask

    task automatic check_slave(input logic [5:0] f, input logic [6:0] a, input logic [2:0] o,
                               input logic expRun, input logic expErr);
        @(posedge clk);
        slaveIn[23:18] <= f;
        slaveIn.stationAddr <= a;
        slaveIn.occupied <= o;
        settle(6);
        chk({30'h0, runLed, errLed}, {30'h0, expRun, expErr});
    endtask

    task automatic blink_tests();
        window();
        slaveIn.stationSwitch <= 4'h3;
        settle(80);
        chk({31'h0, errT >= 3 && errT <= 5}, 32'h1);
        chk({31'h0, errLed}, 32'h0);
        slaveIn.crcError <= 1'b1;
        settle(6);
        window();
        slaveIn.stationSwitch <= 4'h6;
        settle(80);
        chk(errT, 32'h0);
        chk({31'h0, errLed}, 32'h1);
        slaveIn.crcError <= 1'b0;
        reg_read(`FSLE_REG_STATUS);
        chk(rd & 32'h1, 32'h1);
    endtask

    task automatic irq_tests();
        reg_write(`FSLE_REG_MASK, 32'h0);
        check_slave(6'h31, 7'h01, 3'h0, 1'b1, 1'b1);
        check_slave(6'h30, 7'h01, 3'h0, 1'b1, 1'b0);
        reg_read(`FSLE_REG_STATUS);
        chk(rd & 32'h2, 32'h2);
        chk(rd & 32'hc, 32'hc);
        chk({31'h0, irq}, 32'h0);
        reg_write(`FSLE_REG_MASK, 32'h2);
        settle(1);
        chk({31'h0, irq}, 32'h1);
        reg_read(`FSLE_REG_MASK);
        chk(rd, 32'h2);
        settle(1);
        chk(regRdata, 32'h0);
        reg_read(`FSLE_REG_CTRL);
        chk(rd, 32'h1);
        reg_write(`FSLE_REG_STATUS, 32'h2);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        reg_read(`FSLE_REG_STATUS);
        chk(rd & 32'h2, 32'h0);
        reg_write(4'hf, 32'h2);
        reg_read(4'hf);
        chk(rd, 32'h0);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        slaveIn.stationAddr = 7'h01;
        do_reset(4'h0);
        reg_write(`FSLE_REG_CTRL, 32'h0);
        check_master(5'h14, 2'h2, 0);
        check_master(5'h1c, 2'h0, 1);
        check_master(5'h12, 2'h0, 2);
        check_master(5'h1f, 2'h1, 0);
        check_master(5'h06, 2'h0, 0);
        check_master(5'h1e, 2'h0, 2);
        check_master(5'h00, 2'h0, 0);
        reg_write(`FSLE_REG_CTRL, 32'h1);
        check_slave(6'h30, 7'h01, 3'h0, 1'b1, 1'b0);
        reg_read(`FSLE_REG_LED);
        chk(rd & 32'hf, 32'h2);
        check_slave(6'h10, 7'h01, 3'h0, 1'b0, 1'b0);
        check_slave(6'h38, 7'h01, 3'h0, 1'b0, 1'b0);
        check_slave(6'h34, 7'h01, 3'h0, 1'b0, 1'b0);
        check_slave(6'h33, 7'h01, 3'h0, 1'b0, 1'b0);
        check_slave(6'h30, 7'h00, 3'h0, 1'b1, 1'b1);
        check_slave(6'h30, 7'h3c, 3'h5, 1'b1, 1'b1);
        check_slave(6'h30, 7'h3c, 3'h4, 1'b1, 1'b0);
        check_slave(6'h30, 7'h40, 3'h1, 1'b1, 1'b1);
        check_slave(6'h30, 7'h01, 3'h0, 1'b1, 1'b0);
        irq_tests();
        blink_tests();
        do_reset(4'h5);
        reg_write(`FSLE_REG_CTRL, 32'h1);
        check_slave(6'h30, 7'h01, 3'h0, 1'b1, 1'b1);
        do_reset(4'h4);
        reg_write(`FSLE_REG_CTRL, 32'h1);
        check_slave(6'h30, 7'h01, 3'h0, 1'b1, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== verification/fsle_led_observer.sv
/*
 * Operator model: watches the duo and error indicator lines and counts their changes.
 * Assumes the encoder's clock and reset; clr restarts every count.
 */
`timescale 1ns/100ps
`default_nettype none

module fsle_led_observer (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                clr,
    input  wire fsle_pkg::fsle_led_t duoLed,
    input  wire logic                errLed,
    output int                       greenToggles,
    output int                       redToggles,
    output int                       errToggles
);
    fsle_pkg::fsle_led_t duoPrev;
    logic                errPrev;

    // An eye sees only changes, so the pattern is judged by toggles per window.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            duoPrev      <= '0;
            errPrev      <= 1'b0;
            greenToggles <= 0;
            redToggles   <= 0;
            errToggles   <= 0;
        end else begin
            duoPrev <= duoLed;
            errPrev <= errLed;
            if (clr) begin
                greenToggles <= 0;
                redToggles   <= 0;
                errToggles   <= 0;
            end else begin
                greenToggles <= greenToggles + int'(duoLed.green != duoPrev.green);
                redToggles   <= redToggles + int'(duoLed.red != duoPrev.red);
                errToggles   <= errToggles + int'(errLed != errPrev);
            end
        end
    end
endmodule
`default_nettype wire
